// [inc/sfc_pkg.sv]
package sfc_pkg;

  localparam int unsigned OPC_BITS     = 8;
  localparam int unsigned ADDR_BITS    = 24;
  localparam int unsigned DUMMY_BITS   = 32;
  localparam int unsigned BYTE_BITS    = 8;
  localparam int unsigned PAGE_W       = 9;
  localparam int unsigned BYTE_W       = 9;
  localparam int unsigned PAGE_COUNT   = 512;
  localparam int unsigned PAGE_BYTES   = 264;
  localparam int unsigned ARRAY_BYTES  = PAGE_COUNT * PAGE_BYTES;
  localparam int unsigned ARRAY_AW     = 18;

  // Field positions inside the 24-bit address word.
  localparam int unsigned PAGE_LSB     = 9;
  localparam int unsigned BYTE_LSB     = 0;

  localparam logic [7:0] OPC_READ_POL  = 8'h68;
  localparam logic [7:0] OPC_READ_SPI  = 8'he8;
  localparam logic [7:0] OPC_BUF_WRITE = 8'h84;
  localparam logic [7:0] OPC_PROG_ERS  = 8'h83;

  localparam logic [BYTE_W-1:0] LAST_BYTE = 9'h107;

  // Programming time and the cycle count it takes at the system clock.
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned PROG_TIME_NS    = 7000000;
  localparam int unsigned PROG_CYCLES_DEF = PROG_TIME_NS / CLK_PERIOD_NS;

  // Values after reset.
  localparam logic RST_SO    = 1'b0;
  localparam logic RST_SO_OE = 1'b0;
  localparam logic RST_READY = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_OPC    = 3'h1,
    ST_ADDR   = 3'h3,
    ST_DUMMY  = 3'h2,
    ST_STREAM = 3'h6,
    ST_BUFWR  = 3'h7,
    ST_HOLD   = 3'h5,
    ST_IGNORE = 3'h4
  } sfc_state_t;

endpackage

// [inc/sfc_mem_if.sv]
interface sfc_mem_if;
  import sfc_pkg::*;

  logic [PAGE_W-1:0] rd_page;
  logic [BYTE_W-1:0] rd_byte;
  logic [7:0]        rd_data;
  logic              bw_en;
  logic [BYTE_W-1:0] bw_byte;
  logic [7:0]        bw_data;
  logic              pg_start;
  logic [PAGE_W-1:0] pg_page;
  logic              pg_busy;

  modport ctl (
    output rd_page, rd_byte, bw_en, bw_byte, bw_data, pg_start, pg_page,
    input  rd_data, pg_busy
  );

  modport mem (
    input  rd_page, rd_byte, bw_en, bw_byte, bw_data, pg_start, pg_page,
    output rd_data, pg_busy
  );

endinterface

// [logic/sfc_store.sv]
module sfc_store (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  sfc_mem_if.mem    m
);
  import sfc_pkg::*;

  typedef struct packed {
    logic              act;
    logic [BYTE_W-1:0] idx;
    logic [PAGE_W-1:0] page;
  } sfc_store_t;

  sfc_store_t r;
  sfc_store_t next_r;

  logic [7:0]          arr  [0:ARRAY_BYTES-1];
  logic [7:0]          bufm [0:PAGE_BYTES-1];
  logic [ARRAY_AW-1:0] rd_idx;
  logic [ARRAY_AW-1:0] wr_idx;

  assign rd_idx    = ARRAY_AW'(m.rd_page) * ARRAY_AW'(PAGE_BYTES) + ARRAY_AW'(m.rd_byte);
  assign wr_idx    = ARRAY_AW'(r.page) * ARRAY_AW'(PAGE_BYTES) + ARRAY_AW'(r.idx);
  assign m.pg_busy = r.act;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_r = r;
    if (m.pg_start && !r.act)
    begin
      next_r.act  = 1'b1;
      next_r.idx  = '0;
      next_r.page = m.pg_page;
    end
    else if (r.act)
    begin
      if (r.idx == LAST_BYTE)
        next_r.act = 1'b0;
      else
        next_r.idx = r.idx + 9'h001;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      r <= '0;
    else
      r <= next_r;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // The copy overwrites the whole page, so no separate erase is needed.
  always_ff @(posedge i_mclk)
  begin
    m.rd_data <= arr[rd_idx];
    if (r.act)
      arr[wr_idx] <= bufm[r.idx];
    if (m.bw_en && m.bw_byte <= LAST_BYTE)
      bufm[m.bw_byte] <= m.bw_data;
  end

endmodule

// [logic/sfc_top.sv]
module sfc_top #(
  parameter int unsigned PROG_CYCLES = sfc_pkg::PROG_CYCLES_DEF
)(
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_cs_n,
  input  wire logic i_sck,
  input  wire logic i_si,
  output logic      o_so,
  output logic      o_so_oe,
  output logic      o_ready
);
  import sfc_pkg::*;

  localparam int unsigned BUSY_W = $clog2(PROG_CYCLES + 1);

  if (PROG_CYCLES <= PAGE_BYTES)
  begin : g_chk
    $error("PROG_CYCLES must exceed the page copy length");
  end

  typedef struct packed {
    logic [2:0]        pin_s1;
    logic [2:0]        pin_s2;
    logic [2:0]        pin_s3;
    sfc_state_t        st;
    logic [5:0]        cnt;
    logic [23:0]       sr;
    logic [7:0]        opc;
    logic              spi_mode;
    logic [PAGE_W-1:0] rd_page;
    logic [BYTE_W-1:0] rd_byte;
    logic [7:0]        out_sr;
    logic [2:0]        out_cnt;
    logic              so;
    logic              so_oe;
    logic              bw_en;
    logic [BYTE_W-1:0] bw_byte;
    logic [7:0]        bw_data;
    logic              pg_start;
    logic [PAGE_W-1:0] pg_page;
    logic [BUSY_W-1:0] busy_cnt;
    logic              ready;
  } sfc_ctl_t;

  sfc_ctl_t  r;
  sfc_ctl_t  next_r;
  logic [1:0] rst_pipe;
  logic       rst_n;
  logic       cs_low;
  logic       cs_fall;
  logic       cs_rise;
  logic       sck_rise;
  logic       sck_fall;
  logic       shift_evt;
  logic [23:0] sr_in;
  logic [17:0] adv;

  sfc_mem_if mem_if ();

  sfc_store u_store (
    .i_mclk  (i_mclk),
    .i_rst_n (rst_n),
    .m       (mem_if)
  );

  assign mem_if.rd_page  = r.rd_page;
  assign mem_if.rd_byte  = r.rd_byte;
  assign mem_if.bw_en    = r.bw_en;
  assign mem_if.bw_byte  = r.bw_byte;
  assign mem_if.bw_data  = r.bw_data;
  assign mem_if.pg_start = r.pg_start;
  assign mem_if.pg_page  = r.pg_page;

  assign o_so    = r.so;
  assign o_so_oe = r.so_oe;
  assign o_ready = r.ready;

  ////////////////////////////////////////////////////////////////////////////////
  // A byte field past the end of a page folds back to the first byte.
  function automatic logic [BYTE_W-1:0] fold_byte(input logic [BYTE_W-1:0] b);
    if (b > LAST_BYTE)
      fold_byte = '0;
    else
      fold_byte = b;
  endfunction

  function automatic logic [BYTE_W-1:0] inc_byte(input logic [BYTE_W-1:0] b);
    if (b >= LAST_BYTE)
      inc_byte = '0;
    else
      inc_byte = b + 9'h001;
  endfunction

  // Page number wraps modulo 512, so the last page runs into the first.
  function automatic logic [17:0] inc_addr(input logic [PAGE_W-1:0] p,
                                           input logic [BYTE_W-1:0] b);
    if (b >= LAST_BYTE)
      inc_addr = {p + 9'h001, 9'h000};
    else
      inc_addr = {p, b + 9'h001};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Reset is taken at once and released two clock edges later.
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rst_pipe <= 2'h0;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end

  assign rst_n = rst_pipe[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Pins are bit order {cs, sck, si}; edges are seen between stages two and three.
  // Only rising clock edges take input bits, so mode 0 and mode 3 frame alike.
  assign cs_low    = !r.pin_s2[2];
  assign cs_fall   = r.pin_s3[2] && !r.pin_s2[2];
  assign cs_rise   = !r.pin_s3[2] && r.pin_s2[2];
  assign sck_rise  = cs_low && !r.pin_s3[1] && r.pin_s2[1];
  assign sck_fall  = cs_low && r.pin_s3[1] && !r.pin_s2[1];
  assign sr_in     = {r.sr[22:0], r.pin_s2[0]};
  assign adv       = inc_addr(r.rd_page, r.rd_byte);
  assign shift_evt = (r.st == ST_STREAM) && (r.spi_mode ? sck_fall : sck_rise);

  always_comb
  begin
    next_r          = r;
    next_r.pin_s1   = {i_cs_n, i_sck, i_si};
    next_r.pin_s2   = r.pin_s1;
    next_r.pin_s3   = r.pin_s2;
    next_r.bw_en    = 1'b0;
    next_r.pg_start = 1'b0;

    if (r.bw_en)
      next_r.bw_byte = inc_byte(r.bw_byte);

    // Busy counter covers the page copy as well, since it is always longer.
    if (r.busy_cnt != '0)
      next_r.busy_cnt = r.busy_cnt - 1'b1;

    if (cs_rise)
    begin
      if (r.st == ST_HOLD && r.ready)
      begin
        next_r.pg_start = 1'b1;
        next_r.busy_cnt = BUSY_W'(PROG_CYCLES);
      end
      next_r.st    = ST_IDLE;
      next_r.so_oe = 1'b0;
      next_r.so    = 1'b0;
    end
    else if (cs_fall)
    begin
      next_r.st  = ST_OPC;
      next_r.cnt = '0;
    end
    else if (sck_rise)
    begin
      case (r.st)
        ST_OPC:
        begin
          next_r.sr  = sr_in;
          next_r.cnt = r.cnt + 6'h01;
          if (r.cnt == 6'(OPC_BITS - 1))
          begin
            next_r.opc = sr_in[7:0];
            next_r.cnt = '0;
            case (sr_in[7:0])
              OPC_READ_POL, OPC_READ_SPI:
              begin
                // A read whose opcode ends while programming is still running is ignored for the whole frame.
                next_r.st       = r.ready ? ST_ADDR : ST_IGNORE;
                next_r.spi_mode = (sr_in[7:0] == OPC_READ_SPI);
              end
              OPC_BUF_WRITE:
                next_r.st = ST_ADDR;
              OPC_PROG_ERS:
                next_r.st = r.ready ? ST_ADDR : ST_IGNORE;
              default:
                next_r.st = ST_IGNORE;
            endcase
          end
        end

        ST_ADDR:
        begin
          next_r.sr  = sr_in;
          next_r.cnt = r.cnt + 6'h01;
          if (r.cnt == 6'(ADDR_BITS - 1))
          begin
            next_r.cnt = '0;
            case (r.opc)
              OPC_BUF_WRITE:
              begin
                next_r.bw_byte = fold_byte(sr_in[BYTE_LSB +: BYTE_W]);
                next_r.st      = ST_BUFWR;
              end
              OPC_PROG_ERS:
              begin
                next_r.pg_page = sr_in[PAGE_LSB +: PAGE_W];
                next_r.st      = ST_HOLD;
              end
              default:
              begin
                // Upper six bits are dropped; only page and byte fields count.
                next_r.rd_page = sr_in[PAGE_LSB +: PAGE_W];
                next_r.rd_byte = fold_byte(sr_in[BYTE_LSB +: BYTE_W]);
                next_r.st      = ST_DUMMY;
              end
            endcase
          end
        end

        ST_DUMMY:
        begin
          next_r.cnt = r.cnt + 6'h01;
          if (r.cnt == 6'(DUMMY_BITS - 1))
          begin
            // The first byte has been waiting in the read port since the address.
            next_r.st      = ST_STREAM;
            next_r.so_oe   = 1'b1;
            next_r.rd_page = adv[17:9];
            next_r.rd_byte = adv[8:0];
            if (r.spi_mode)
            begin
              next_r.out_sr  = mem_if.rd_data;
              next_r.out_cnt = 3'h0;
            end
            else
            begin
              next_r.so      = mem_if.rd_data[7];
              next_r.out_sr  = {mem_if.rd_data[6:0], 1'b0};
              next_r.out_cnt = 3'h1;
            end
          end
        end

        ST_BUFWR:
        begin
          next_r.sr  = sr_in;
          next_r.cnt = r.cnt + 6'h01;
          if (r.cnt == 6'(BYTE_BITS - 1))
          begin
            next_r.cnt     = '0;
            next_r.bw_en   = 1'b1;
            next_r.bw_data = sr_in[7:0];
          end
        end

        default:
          next_r.st = r.st;
      endcase
    end

    // The stream reads only the array port; the buffer is never addressed here.
    if (shift_evt && !cs_rise)
    begin
      next_r.so = r.out_sr[7];
      if (r.out_cnt == 3'h7)
      begin
        next_r.out_sr  = mem_if.rd_data;
        next_r.out_cnt = 3'h0;
        next_r.rd_page = adv[17:9];
        next_r.rd_byte = adv[8:0];
      end
      else
      begin
        next_r.out_sr  = {r.out_sr[6:0], 1'b0};
        next_r.out_cnt = r.out_cnt + 3'h1;
      end
    end

    next_r.ready = (next_r.busy_cnt == '0) && !next_r.pg_start && !mem_if.pg_busy;
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r        <= '0;
      r.pin_s1 <= 3'h6;
      r.pin_s2 <= 3'h6;
      r.pin_s3 <= 3'h6;
      r.st     <= ST_IDLE;
      r.so     <= RST_SO;
      r.so_oe  <= RST_SO_OE;
      r.ready  <= RST_READY;
    end
    else
      r <= next_r;
  end

endmodule

// [tb/sfc_top_sva.sv]
module sfc_top_sva #(
  parameter int unsigned PROG_CYCLES = 300
)(
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_cs_n,
  input  wire logic i_sck,
  input  wire logic i_si,
  input  wire logic o_so,
  input  wire logic o_so_oe,
  input  wire logic o_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned busy_cnt;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////
  // Busy length gets two cycles of slack, since the pins pass synchronisers.
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      busy_cnt <= 0;
    else
      busy_cnt <= o_ready ? 0 : busy_cnt + 1;
  end
  property p_oe_drop;
    i_cs_n [*5] |-> !o_so_oe;
  endproperty
  a_oe_drop: assert property (p_oe_drop)
    else $error("so enable held after frame end");
  property p_so_zero;
    !o_so_oe |-> !o_so;
  endproperty
  a_so_zero: assert property (p_so_zero)
    else $error("so driven while released");
  property p_oe_start;
    $rose(o_so_oe) |-> $past(i_sck, 3) && !$past(i_sck, 6);
  endproperty
  a_oe_start: assert property (p_oe_start)
    else $error("so enable rose without a rising sck");
  property p_so_edge;
    o_so_oe && $past(o_so_oe) && $changed(o_so) |-> $past(i_sck, 3) != $past(i_sck, 6);
  endproperty
  a_so_edge: assert property (p_so_edge)
    else $error("so changed without an sck edge");
  property p_so_quiet;
    (o_so_oe && $stable(i_sck)) [*6] |=> !o_so_oe || $stable(o_so);
  endproperty
  a_so_quiet: assert property (p_so_quiet)
    else $error("so moved while sck stood still");
  property p_busy_no_out;
    !o_ready |-> !o_so_oe;
  endproperty
  a_busy_no_out: assert property (p_busy_no_out)
    else $error("array output while busy");
  property p_busy_after_cs;
    $fell(o_ready) |-> $past(i_cs_n, 2) && $past(i_cs_n, 3);
  endproperty
  a_busy_after_cs: assert property (p_busy_after_cs)
    else $error("busy began inside a frame");
  property p_busy_len;
    $rose(o_ready) |-> busy_cnt + 2 >= PROG_CYCLES && busy_cnt <= PROG_CYCLES + 2;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("programming time wrong");
endmodule

bind sfc_top sfc_top_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (
  .i_mclk  (i_mclk),
  .i_rst_n (i_rst_n),
  .i_cs_n  (i_cs_n),
  .i_sck   (i_sck),
  .i_si    (i_si),
  .o_so    (o_so),
  .o_so_oe (o_so_oe),
  .o_ready (o_ready)
);

// [tb/sfc_host.sv]
module sfc_host (
  input  wire logic i_mclk,
  input  wire logic i_so,
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_si
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_byte;
  event       got;
  initial
  begin
    o_cs_n = 1'b1;
    o_sck  = 1'b1;
    o_si   = 1'b0;
  end
  ////////////////////////////////////////
  // SO is sampled late in each phase, well clear of the device's latency.
  task automatic half(input logic lvl, input logic b, output logic s);
    o_sck <= lvl;
    o_si  <= b;
    repeat (5) @(posedge i_mclk);
    @(negedge i_mclk) s = i_so;
    @(posedge i_mclk);
  endtask
  task automatic shift8(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      half(1'b0, d[i], s);
      half(1'b1, d[i], s);
    end
  endtask
  task automatic shift32(input logic [31:0] d);
    for (int j = 3; j >= 0; j--)
      shift8(d[8*j +: 8]);
  endtask
  task automatic open(input logic idle);
    o_sck <= idle;
    repeat (6) @(posedge i_mclk);
    o_cs_n <= 1'b0;
    repeat (6) @(posedge i_mclk);
  endtask
  task automatic close(input logic idle);
    o_sck <= idle;
    repeat (6) @(posedge i_mclk);
    o_cs_n <= 1'b1;
    o_si   <= ~o_si;
    repeat (8) @(posedge i_mclk);
  endtask
  task automatic read(input logic on_fall, input int n);
    logic lo;
    logic hi;
    for (int k = 0; k < n; k++)
    begin
      for (int i = 7; i >= 0; i--)
      begin
        half(1'b0, ~o_si, lo);
        half(1'b1, o_si, hi);
        rx_byte[i] = on_fall ? hi : lo;
      end
      -> got;
    end
  endtask
endmodule

// [tb/test_sfc_top.sv]
module test_sfc_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sfc_pkg::*;
  localparam int unsigned PROG  = 300;
  localparam int unsigned LIMIT = 40000;
  localparam logic [8:0]  PGS [3] = '{9'h000, 9'h001, 9'h1ff};
  logic       i_mclk;
  logic       i_rst_n;
  wire        cs_n;
  wire        sck;
  wire        si;
  logic       o_so;
  logic       o_so_oe;
  logic       o_ready;
  logic [7:0] d;
  logic [7:0] e;
  logic [7:0] expq [$];
  logic [7:0] pm [3][264];
  int         fail_count;
  int         compares;
  int         cyc;
  // A released SO line toggles, so a stale bit can never pass for data.
  wire        so_line = o_so_oe ? o_so : cyc[0];
  `define CHK(a, x) \
    begin \
      compares++; \
      if ((a) !== (x)) \
      begin \
        fail_count++; \
        $display("unexpected at %0t: got %h expected %h", $time, (a), (x)); \
      end \
    end
  sfc_top #(.PROG_CYCLES(PROG)) dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cs_n(cs_n),
    .i_sck(sck), .i_si(si), .o_so(o_so), .o_so_oe(o_so_oe), .o_ready(o_ready));
  sfc_host host (.i_mclk(i_mclk), .i_so(so_line), .o_cs_n(cs_n), .o_sck(sck), .o_si(si));
  initial i_mclk = 1'b0;
  always #12.5 i_mclk = ~i_mclk;
  ////////////////////////////////////////
  task automatic end_sim();
    if (fail_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic ready_wait();
    repeat (2 * PROG)
    begin
      @(negedge i_mclk);
      if (o_ready === 1'b1)
        break;
    end
    `CHK(o_ready, 1'b1)
    @(posedge i_mclk);
  endtask
  task automatic commit(input logic [8:0] pg);
    ready_wait();
    host.open(1'b1);
    host.shift32({OPC_PROG_ERS, 6'($urandom), pg, 9'($urandom)});
    host.close(1'b1);
    @(negedge i_mclk);
    `CHK(o_ready, 1'b0)
    @(posedge i_mclk);
  endtask
  task automatic rd(input logic [7:0] opc, input logic idle, input logic [8:0] pg,
                    input logic [8:0] b, input int n);
    ready_wait();
    host.open(idle);
    host.shift32({opc, 6'($urandom), pg, b});
    host.shift32($urandom);
    for (int k = 0; k < n; k++)
    begin
      expq.push_back(pm[pg == 9'h1ff ? 2 : pg][b]);
      b  = (b == LAST_BYTE) ? 9'h000 : b + 9'h001;
      pg = (b == 9'h000) ? pg + 9'h001 : pg;
    end
    host.read(opc == OPC_READ_SPI, n);
    host.close(idle);
  endtask
  always @(host.got)
  begin
    e = expq.pop_front();
    `CHK(host.rx_byte, e)
  end
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      fail_count++;
      end_sim();
    end
  end
  initial
  begin
    i_rst_n    = 1'b0;
    fail_count = 0;
    compares   = 0;
    cyc        = 0;
    d          = 8'($urandom(67));
    repeat (10) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(negedge i_mclk);
    `CHK({o_so, o_so_oe, o_ready}, 3'h1)
    repeat (6) @(posedge i_mclk);
    // Each load after the first opens while the previous page is still programming; its data bytes land after that ends.
    for (int i = 0; i < 3; i++)
    begin
      host.open(1'b0);
      host.shift32({OPC_BUF_WRITE, 15'($urandom), 9'h104});
      for (int k = 0; k < 8; k++)
      begin
        d = 8'($urandom);
        pm[i][(260 + k) % PAGE_BYTES] = d;
        host.shift8(d);
      end
      host.close(1'b0);
      commit(PGS[i]);
    end
    rd(OPC_READ_SPI, 1'b1, 9'h1ff, 9'h106, 4);
    rd(OPC_READ_POL, 1'b0, 9'h000, 9'h104, 8);
    rd(OPC_READ_SPI, 1'b0, 9'h000, 9'h107, 2);
    rd(OPC_READ_POL, 1'b1, 9'h1ff, 9'h107, 2);
    pm[1] = pm[2];
    commit(9'h001);
    // A read opened while the page still programs must leave the output released.
    host.open(1'b0);
    host.shift32({OPC_READ_POL, 24'($urandom)});
    host.shift32($urandom);
    @(negedge i_mclk);
    `CHK(o_so_oe, 1'b0)
    @(posedge i_mclk);
    host.close(1'b0);
    rd(OPC_READ_SPI, 1'b0, 9'h001, 9'h104, 4);
    `CHK(expq.size(), 0)
    end_sim();
  end
endmodule
